// File: hdl/dlr_lane_rx.sv
// Purpose: Lane-level receive control: entry, exit, turnaround, termination, data type.
// Assumes: Line states arrive as raw pin levels; link clock is the host's HS bit clock.
// Notes:   Lane 0 decodes all data lane sequences; the other data lanes follow its termination.
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Data types 0Eh, 1Eh, 2Eh, 3Eh select 565, packed 666, loose 666, 888.
// (R2) Host keeps 24-UI pixel lane rate within 850/650/550 Mbps by lanes.
// (R3) Host keeps packed 18-bit lane rate within 637/487/412 Mbps by lanes.
// (R4) Every low-power state on lane 0 lasts 50 to 75 ns.
// (R5) After host hands over lane 0, wait one to two periods before driving.
// (R6) On takeover, device drives LP-00 for five periods.
// (R7) Host drives LP-00 for four device periods before releasing lane 0.
// (R8) Host enters high speed via LP-11, LP-01, LP-00, then HS-0.
// (R9) Host holds LP-00 during entry 40+4UI to 85+6UI ns.
// (R10) Data termination enables within 35+4UI ns of the lane going low.
// (R11) Host inverts last payload bit and holds it until burst closes.
// (R12) Device ignores lane for 40 to 55+4UI ns after end of burst.
// (R13) Host drives LP-11 at least 100 ns after a burst.
// (R14) Host holds clock lane LP-11 at least 100 ns after HS period.
// (R15) Host keeps HS clock 60+52UI ns after data lanes return to LP.
// (R16) Host holds clock prepare 38 to 95 ns before HS-0.
// (R17) Clock termination enables within 38 ns of clock prepare detection.
// (R18) Clock prepare plus HS-0 lead-in lasts at least 300 ns.
// (R19) HS clock runs 8 UI before any data lane starts entry.
// (R20) Low-power states shorter than the minimum period are ignored as glitches.
module dlr_lane_rx
    import dlr_pkg::*;
#(
    parameter int NLANES = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic              i_hs_clk,
    input  wire logic [1:0]        i_d0_lp,
    input  wire logic [1:0]        i_ck_lp,
    input  wire logic              i_hs_d0,
    input  wire logic              i_resp_hold,
    output logic      [1:0]        o_d0_lp,
    output logic                   o_d0_oe,
    output logic      [NLANES-1:0] o_data_term_en,
    output logic                   o_clk_term_en,
    output logic                   o_hs_active,
    output logic                   o_hs_skip,
    output logic                   o_lane_owned,
    output dlr_pix_t               o_pix,
    output logic                   o_pix_vld
);
    dlr_sys_t   q;
    dlr_sys_t   d;
    dlr_lnk_t   lq;
    dlr_lnk_t   ld;
    logic [4:0] sys_in;
    logic [1:0] lnk_in;
    logic       hs_en;

    // Pins and the link toggle are foreign to this clock
    dlr_sync #(.W(5)) u_sys_sync (
        .i_clk (i_clk),
        .i_ce  (i_ce),
        .i_d   ({lq.tog, i_ck_lp, i_d0_lp}),
        .o_q   (sys_in)
    );

    // Reset and burst level carried into the link domain
    dlr_sync #(.W(2)) u_lnk_sync (
        .i_clk (i_hs_clk),
        .i_ce  (1'b1),
        .i_d   ({i_rst, q.st == ST_HS_RX}),
        .o_q   (lnk_in)
    );
    assign hs_en = lnk_in[0] & ~lnk_in[1];

    // Link domain: hunt the sync byte then catch the data identifier once per burst.
    // Capture ends when the burst level drops, which the host still clocks through. (R15)
    always_comb begin
        ld = lq;
        if (!hs_en) begin
            ld.sh     = 8'h00;
            ld.bits   = 3'h0;
            ld.locked = 1'b0;
            ld.done   = 1'b0;
            ld.tog    = 1'b0;
        end else if (!lq.done) begin
            ld.sh = {i_hs_d0, lq.sh[7:1]};
            if (!lq.locked) begin
                ld.locked = ({i_hs_d0, lq.sh[7:1]} == HS_SYNC);
            end else begin
                ld.bits = lq.bits + 3'h1;
                if (lq.bits == 3'(DI_BITS - 1)) begin
                    ld.code = ld.sh[5:0];
                    ld.done = 1'b1;
                    // Level flag, not a toggle: it clears itself while the clock runs
                    // before entry, so the stopped link clock needs no reset of its own
                    ld.tog  = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_hs_clk) begin
        lq <= ld;
    end

    // System domain: filters, lane 0 sequencer, termination, format report
    always_comb begin
        logic [1:0] f;
        logic [1:0] fp;
        f  = q.lp_f[0];
        fp = q.lp_f[0];
        d  = q;
        d.pix_vld = 1'b0;
        d.skip    = 1'b0;
        // Accept a state only once seen on consecutive samples (R20)
        for (int i = 0; i < 2; i++) begin
            d.lp_prev[i] = sys_in[2*i +: 2];
            if (sys_in[2*i +: 2] != q.lp_prev[i]) begin
                d.stab[i] = 4'h0;
            end else if (q.stab[i] != 4'hF) begin
                d.stab[i] = q.stab[i] + 4'h1;
            end
            if (sys_in[2*i +: 2] == q.lp_prev[i] && d.stab[i] >= 4'(LP_MIN_CYC)) begin
                d.lp_f[i] = sys_in[2*i +: 2]; // R20
            end
        end
        f = d.lp_f[0];
        // Clock lane: LP-01 arms, LP-00 switches termination on, LP-11 off
        if (d.lp_f[1] == LP_01) begin
            d.ck_arm = 1'b1;
        end else if (d.lp_f[1] == LP_00 && q.ck_arm) begin
            d.ck_term = 1'b1; // R17
        end else if (d.lp_f[1] == LP_11) begin
            d.ck_arm  = 1'b0;
            d.ck_term = 1'b0;
        end
        // Data identifier arrives once per burst on the rising edge of the link flag
        d.tog = sys_in[4];
        if (sys_in[4] && !q.tog) begin
            d.pix_vld  = 1'b1;
            d.pix.code = lq.code;
            d.pix.bad  = 1'b0;
            unique case (lq.code)
                DT_565:  d.pix.fmt = FMT_565;  // R1
                DT_666P: d.pix.fmt = FMT_666P; // R1
                DT_666L: d.pix.fmt = FMT_666L; // R1
                DT_888:  d.pix.fmt = FMT_888;  // R1
                default: begin
                    d.pix.fmt = FMT_NONE;
                    d.pix.bad = 1'b1;
                end
            endcase
        end
        // Lane 0 sequencer; each state decision uses filtered levels only
        unique case (q.st)
            ST_STOP: begin
                d.drv = '{lvl: LP_11, oe: 1'b0};
                if (f == LP_01 && fp != LP_01) d.st = ST_HS_RQST;
                else if (f == LP_10 && fp != LP_10) d.st = ST_LPRQ;
            end
            ST_HS_RQST: begin
                if (f == LP_00) d.st = ST_HS_RX; // R10
                else if (f != LP_01) d.st = ST_STOP;
            end
            ST_HS_RX: begin
                if (f == LP_11) begin
                    d.st   = ST_SKIP;
                    d.cnt  = 4'h0;
                    d.skip = 1'b1; // R12
                end
            end
            ST_SKIP: begin
                // Trailer edges during this window never reach the decoder
                d.cnt = q.cnt + 4'h1;
                if (q.cnt + 4'h1 >= 4'(SKIP_CYC)) d.st = ST_STOP;
                else d.skip = 1'b1; // R12
            end
            ST_LPRQ: begin
                if (f == LP_00) d.st = ST_LPY;
                else if (f != LP_10) d.st = ST_STOP;
            end
            ST_LPY: begin
                if (f == LP_10) d.st = ST_BTA_RQ;
                else if (f != LP_00) d.st = ST_STOP;
            end
            ST_BTA_RQ: begin
                d.cnt = 4'h0;
                if (f == LP_00) d.st = ST_TA_GO;
                else if (f != LP_10) d.st = ST_STOP;
            end
            ST_TA_GO: begin
                // Host holds LP-00 for its go period, then lets go (R7)
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == 4'(TA_GO_N * TLPXD_CYC - 1)) begin
                    d.st  = ST_TA_SURE;
                    d.cnt = 4'h0;
                end
            end
            ST_TA_SURE: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == 4'(TA_SURE_N * TLPXD_CYC - 1)) begin
                    d.st  = ST_TA_GET; // R5
                    d.cnt = 4'h0;
                    d.drv = '{lvl: LP_00, oe: 1'b1};
                end
            end
            ST_TA_GET: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == 4'(TA_GET_N * TLPXD_CYC - 1)) begin
                    d.st  = ST_OWN; // R6
                    d.cnt = 4'h0;
                    d.drv = '{lvl: LP_10, oe: 1'b1};
                end
            end
            ST_OWN: begin
                // One period of LP-10, then stop state if i_resp_hold is high, else straight on into the hand-back request
                d.cnt = (q.cnt == 4'hF) ? q.cnt : q.cnt + 4'h1;
                if (!q.give) begin
                    if (q.cnt >= 4'(TLPXD_CYC - 1)) d.drv.lvl = LP_11; // R4
                    if (!i_resp_hold && q.cnt >= 4'(TLPXD_CYC - 1)) begin
                        d.give    = 1'b1;
                        d.cnt     = 4'h0;
                        d.drv.lvl = LP_10;
                    end
                end else begin
                    // 10, 00, 10, then LP-00 for the go period, one period per step
                    d.cnt = q.cnt + 4'h1;
                    unique case (q.cnt)
                        4'h0:    d.drv.lvl = LP_00; // R4
                        4'h1:    d.drv.lvl = LP_10; // R4
                        default: d.drv.lvl = LP_00;
                    endcase
                    if (q.cnt == 4'(2 + TA_GO_N * TLPXD_CYC)) begin
                        d.st   = ST_STOP;
                        d.give = 1'b0;
                        d.drv  = '{lvl: LP_11, oe: 1'b0};
                    end
                end
            end
        endcase
        if (i_rst) begin
            d       = '0;
            d.st    = ST_STOP;
            d.drv   = '{lvl: LP_11, oe: 1'b0};
            d.lp_f  = {LP_11, LP_11};
            d.tog   = 1'b1;
        end else if (!i_ce) begin
            d = q;
        end
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    // Outputs; data termination follows the lane 0 burst state for all data lanes
    assign o_d0_lp        = q.drv.lvl;
    assign o_d0_oe        = q.drv.oe;
    assign o_data_term_en = {NLANES{q.st == ST_HS_RX}}; // R10
    assign o_clk_term_en  = q.ck_term;
    assign o_hs_active    = (q.st == ST_HS_RX);
    assign o_hs_skip      = q.skip;
    assign o_lane_owned   = q.drv.oe;
    assign o_pix          = q.pix;
    assign o_pix_vld      = q.pix_vld;

    // Checks
    a_fmt_code_map: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        q.pix_vld |-> (q.pix.fmt == FMT_888) == (q.pix.code == DT_888)
                   && (q.pix.fmt == FMT_565) == (q.pix.code == DT_565)
                   && (q.pix.fmt == FMT_666P) == (q.pix.code == DT_666P))
        else $error("pixel format does not match data type");
    a_give_step_len: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R4
        $rose(q.give) |=> (q.drv.lvl == LP_00) ##1 (q.drv.lvl == LP_10)
                          ##1 (q.drv.lvl == LP_00))
        else $error("hand-back state not one period");
    a_ta_sure_wait: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R5
        $rose(q.st == ST_TA_SURE) |-> !o_d0_oe ##1 o_d0_oe)
        else $error("drive did not start one period after release");
    a_ta_get_hold: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R6
        $rose(o_d0_oe) |-> (o_d0_oe && o_d0_lp == LP_00) [*5] ##1 (o_d0_lp == LP_10))
        else $error("takeover LP-00 not five periods");
    a_term_on_entry: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R10
        (q.st == ST_HS_RQST && d.lp_f[0] == LP_00) |=> o_data_term_en[0])
        else $error("data termination late");
    a_skip_window: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R12
        $fell(o_hs_active) |-> o_hs_skip ##1 (!o_hs_skip && q.st == ST_STOP))
        else $error("skip window wrong length");
    a_clk_term_on: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R17
        (q.ck_arm && d.lp_f[1] == LP_00) |=> o_clk_term_en)
        else $error("clock termination late");
    a_glitch_reject: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R20
        $changed(q.lp_f[0]) |-> $past(sys_in[1:0]) == $past(q.lp_prev[0]))
        else $error("single-sample state accepted");
endmodule : dlr_lane_rx
`default_nettype wire

// File: hdl/dlr_pkg.sv
// Purpose: Shared constants and types for the lane receiver timing block.
// Assumes: System clock of 20 MHz; line states coded {dp, dn}.
// Notes:   Cycle counts derive from nanosecond figures and the clock period.
package dlr_pkg;

    // System clock period
    localparam int CLK_PERIOD_NS = 50;

    // Cycle conversion: least times round up, longest times round down, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    function automatic int cyc_dn(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_dn

    // Low-power state period limits and derived counts
    localparam int TLPX_MIN_NS     = 50;
    localparam int TLPX_MAX_NS     = 75;
    localparam int LP_MIN_CYC      = cyc_up(TLPX_MIN_NS);
    localparam int TLPXD_CYC       = cyc_dn(TLPX_MAX_NS);
    // Turnaround multiples of the device period
    localparam int TA_GO_N         = 4;
    localparam int TA_SURE_N       = 1;
    localparam int TA_GET_N        = 5;
    // End-of-burst skip window and termination deadlines
    localparam int HS_SKIP_MIN_NS  = 40;
    localparam int HS_SKIP_MAX_NS  = 55;
    localparam int SKIP_CYC        = cyc_up(HS_SKIP_MIN_NS);
    localparam int TERM_EN_MAX_NS  = 35;
    localparam int CLK_TERM_MAX_NS = 38;
    localparam int CLK_POST_MIN_NS = 60;

    // Host-side lane rate ceilings in Mbps, by lane count 2..4
    localparam int RATE_24UI_MBPS [2:4] = '{850, 650, 550};
    localparam int RATE_18UI_MBPS [2:4] = '{637, 487, 412};

    // Line state codes {dp, dn}
    localparam logic [1:0] LP_00 = 2'h0;
    localparam logic [1:0] LP_01 = 2'h1;
    localparam logic [1:0] LP_10 = 2'h2;
    localparam logic [1:0] LP_11 = 2'h3;

    // Pixel stream data types, sync byte and identifier length
    localparam logic [5:0] DT_565    = 6'h0E;
    localparam logic [5:0] DT_666P   = 6'h1E;
    localparam logic [5:0] DT_666L   = 6'h2E;
    localparam logic [5:0] DT_888    = 6'h3E;
    localparam logic [7:0] HS_SYNC   = 8'hB8;
    localparam int         DI_BITS   = 8;

    typedef enum logic [2:0] {
        FMT_NONE = 3'h0,
        FMT_565  = 3'h1,
        FMT_666P = 3'h2,
        FMT_666L = 3'h3,
        FMT_888  = 3'h4
    } dlr_fmt_t;

    // Data lane 0 controller states, one-hot
    typedef enum logic [10:0] {
        ST_STOP    = 11'h001,
        ST_HS_RQST = 11'h002,
        ST_HS_RX   = 11'h004,
        ST_SKIP    = 11'h008,
        ST_LPRQ    = 11'h010,
        ST_LPY     = 11'h020,
        ST_BTA_RQ  = 11'h040,
        ST_TA_GO   = 11'h080,
        ST_TA_SURE = 11'h100,
        ST_TA_GET  = 11'h200,
        ST_OWN     = 11'h400
    } dlr_st_t;

    // Drive of the two-way lane 0 pins
    typedef struct packed {
        logic [1:0] lvl;
        logic       oe;
    } dlr_drv_t;

    // Recognised pixel format report
    typedef struct packed {
        dlr_fmt_t   fmt;
        logic [5:0] code;
        logic       bad;
    } dlr_pix_t;

    // System-domain state
    typedef struct packed {
        dlr_st_t         st;
        logic [3:0]      cnt;
        logic            give;
        logic [1:0][1:0] lp_f;
        logic [1:0][1:0] lp_prev;
        logic [1:0][3:0] stab;
        logic            ck_arm;
        logic            ck_term;
        logic            skip;
        logic            tog;
        dlr_drv_t        drv;
        dlr_pix_t        pix;
        logic            pix_vld;
    } dlr_sys_t;

    // Link-domain state
    typedef struct packed {
        logic [7:0] sh;
        logic [2:0] bits;
        logic       locked;
        logic       done;
        logic [5:0] code;
        logic       tog;
    } dlr_lnk_t;

endpackage : dlr_pkg

// File: hdl/dlr_sync.sv
// Purpose: Two-flop synchroniser for level signals entering a clock domain.
// Assumes: Each bit is an independent level; no bus coherence across bits.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module dlr_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [1:0][W-1:0] stg_q;
    logic [1:0][W-1:0] stg_d;

    // Shift by one stage while enabled
    always_comb begin
        stg_d = stg_q;
        if (i_ce) begin
            stg_d[0] = i_d;
            stg_d[1] = stg_q[0];
        end
    end

    always_ff @(posedge i_clk) begin
        stg_q <= stg_d;
    end

    assign o_q = stg_q[1];
endmodule : dlr_sync
`default_nettype wire

// File: tb/dlr_host_model.sv
// Purpose: Host-side model of the display link: clock lane, lane 0 LP states, HS bursts.
// Assumes: Each LP state except a glitch pulse is held long enough for the receiver filter to accept it.
// Notes:   Bit clock runs only inside bursts; a released lane does not keep its old level.
`timescale 1ns/1ps
`default_nettype none
module dlr_host_model
    import dlr_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [1:0] i_dev_lp,
    input  wire logic       i_dev_oe,
    output logic      [1:0] o_d0_lp,
    output logic      [1:0] o_ck_lp,
    output logic            o_hs_clk,
    output logic            o_hs_d0
);
    logic [1:0] lvl_q    = LP_11;
    logic       drv_en   = 1'b1;
    logic       ck_run   = 1'b0;
    logic       bit_q    = 1'b0;
    logic       in_burst = 1'b0;

    // Device drive wins; an undriven lane shows the inverse so stale values cannot pass
    assign o_d0_lp = i_dev_oe ? i_dev_lp : (drv_en ? lvl_q : ~lvl_q);
    assign o_hs_d0 = in_burst ? bit_q : ~bit_q;

    // 15 ns bit clock, far below every lane rate ceiling, still between bursts
    initial begin
        o_ck_lp  = LP_11;
        o_hs_clk = 1'b0;
        #3.3;
        forever begin
            #7.5;
            o_hs_clk = ck_run ? ~o_hs_clk : 1'b0;
        end
    end

    // Hold one lane 0 level for n system cycles
    task automatic lp(input logic [1:0] v, input int n);
        lvl_q  = v;
        drv_en = 1'b1;
        repeat (n) @(posedge i_clk);
        #1;
    endtask : lp

    // Short pulse that spans a single system clock sample
    task automatic glitch(input logic [1:0] v);
        #9;
        lvl_q = v;
        #45;
        lvl_q = LP_11;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : glitch

    // Turnaround request, then the lane is let go
    task automatic bta();
        lp(LP_10, 3);
        lp(LP_00, 3);
        lp(LP_10, 3);
        lp(LP_00, 4);
        drv_en = 1'b0;
    endtask : bta

    task automatic take_back();
        lvl_q  = LP_11;
        drv_en = 1'b1;
    endtask : take_back

    // Bits change on the falling clock edge, least significant first
    task automatic hs_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge o_hs_clk);
            bit_q = b[i];
        end
    endtask : hs_byte

    // Clock lane start, data entry, sync byte, identifier, trailer, exit
    task automatic burst(input logic [5:0] code);
        o_ck_lp = LP_01;
        repeat (3) @(posedge i_clk);
        #1;
        o_ck_lp = LP_00;
        repeat (7) @(posedge i_clk);
        ck_run = 1'b1;
        repeat (16) @(posedge o_hs_clk);
        @(posedge i_clk);
        #1;
        lp(LP_01, 3);
        lp(LP_00, 3);
        in_burst = 1'b1;
        bit_q    = 1'b0;
        repeat (48) @(negedge o_hs_clk);
        hs_byte(HS_SYNC);
        hs_byte({2'b00, code});
        @(negedge o_hs_clk);
        bit_q = ~bit_q;
        repeat (8) @(negedge o_hs_clk);
        @(posedge i_clk);
        #1;
        in_burst = 1'b0;
        lp(LP_11, 18);
        ck_run  = 1'b0;
        o_ck_lp = LP_11;
        lp(LP_11, 3);
    endtask : burst
endmodule : dlr_host_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the lane receiver timing block.
// Assumes: Host model drives all lane pins; outputs sampled on the falling clock edge.
// Notes:   Sampling away from the rising edge keeps results free of race order.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dlr_pkg::*;
;
    localparam int NL = 4;
    logic            i_clk       = 1'b0;
    logic            i_rst       = 1'b1;
    logic            i_ce        = 1'b1;
    logic            i_resp_hold = 1'b0;
    logic [1:0]      d0_lp, ck_lp, dev_lp;
    logic            hs_clk, hs_d0, dev_oe, clk_term, hs_active, hs_skip, owned, pix_vld;
    logic [NL-1:0]   data_term;
    dlr_pix_t        pix, pix_seen;
    int              n_errors = 0;
    int              n_checks = 0;
    int              pix_cnt  = 0;
    logic [5:0]      codes [5] = '{DT_565, DT_666P, DT_666L, DT_888, 6'h39};
    dlr_fmt_t        fmts [5]  = '{FMT_565, FMT_666P, FMT_666L, FMT_888, FMT_NONE};

    dlr_lane_rx #(.NLANES(NL)) dlr_lane_rx_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_hs_clk(hs_clk), .i_d0_lp(d0_lp),
        .i_ck_lp(ck_lp), .i_hs_d0(hs_d0), .i_resp_hold(i_resp_hold), .o_d0_lp(dev_lp),
        .o_d0_oe(dev_oe), .o_data_term_en(data_term), .o_clk_term_en(clk_term),
        .o_hs_active(hs_active), .o_hs_skip(hs_skip), .o_lane_owned(owned),
        .o_pix(pix), .o_pix_vld(pix_vld));

    dlr_host_model dlr_host_model_inst (
        .i_clk(i_clk), .i_dev_lp(dev_lp), .i_dev_oe(dev_oe), .o_d0_lp(d0_lp),
        .o_ck_lp(ck_lp), .o_hs_clk(hs_clk), .o_hs_d0(hs_d0));

    initial begin
        forever #25 i_clk = ~i_clk;
    end

    // Type reports are one-cycle pulses, so count them as they come
    always @(negedge i_clk) begin
        if (pix_vld === 1'b1) begin
            pix_cnt++;
            pix_seen = pix;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // Sub-period pulses and a skipped entry step must leave the lane idle
    task automatic t_glitch();
        int i;
        int bad_n;
        bad_n = 0;
        @(posedge i_clk);
        #1;
        fork
            begin
                dlr_host_model_inst.glitch(LP_01);
                dlr_host_model_inst.glitch(LP_10);
                dlr_host_model_inst.lp(LP_00, 3);
                dlr_host_model_inst.lp(LP_11, 3);
            end
            for (i = 0; i < 20; i++) begin
                @(negedge i_clk);
                if (hs_active !== 1'b0 || data_term !== '0 || dev_oe !== 1'b0) bad_n++;
            end
        join
        check("idle lane", 0, bad_n);
    endtask : t_glitch

    // Host hands lane 0 over, device takes it, holds it, then hands it back
    task automatic t_turn();
        logic [1:0] seq [7] = '{LP_10, LP_00, LP_10, LP_00, LP_00, LP_00, LP_00};
        int i;
        int n;
        i_resp_hold = 1'b1;
        @(posedge i_clk);
        #1;
        dlr_host_model_inst.bta();
        check("drive at release", 0, dev_oe);
        for (i = 0; i < 16 && dev_oe !== 1'b1; i++) @(negedge i_clk);
        check("lane taken", 1, dev_oe);
        for (n = 0; n < 8 && dev_oe === 1'b1 && dev_lp === LP_00; n++) @(negedge i_clk);
        check("takeover low run", TA_GET_N, n);
        check("takeover signal", LP_10, dev_lp);
        @(negedge i_clk);
        check("owned level", LP_11, dev_lp);
        repeat (4) @(negedge i_clk);
        check("ownership held", 1, owned);
        @(posedge i_clk);
        #1;
        i_resp_hold = 1'b0;
        for (i = 0; i < 10 && dev_lp !== LP_10; i++) @(negedge i_clk);
        for (i = 0; i < 7; i++) begin
            check("hand-back level", seq[i], dev_lp);
            @(negedge i_clk);
        end
        check("hand-back release", 0, dev_oe);
        @(posedge i_clk);
        #1;
        dlr_host_model_inst.take_back();
        repeat (4) @(negedge i_clk);
    endtask : t_turn

    // A full entry sequence while the enable is low must not move the lane state
    task automatic t_freeze();
        int i;
        int bad_n;
        bad_n = 0;
        @(posedge i_clk);
        #1;
        i_ce = 1'b0;
        fork
            begin
                dlr_host_model_inst.lp(LP_01, 3);
                dlr_host_model_inst.lp(LP_00, 3);
                dlr_host_model_inst.lp(LP_11, 1);
                i_ce = 1'b1;
                dlr_host_model_inst.lp(LP_11, 3);
            end
            for (i = 0; i < 12; i++) begin
                @(negedge i_clk);
                if (hs_active !== 1'b0 || data_term !== '0 || dev_oe !== 1'b0) bad_n++;
            end
        join
        check("frozen lane", 0, bad_n);
    endtask : t_freeze

    // One full burst carrying the given identifier code
    task automatic t_burst(input logic [5:0] code, input dlr_fmt_t fmt, input logic bad);
        int i;
        pix_cnt = 0;
        @(posedge i_clk);
        #1;
        fork
            dlr_host_model_inst.burst(code);
            begin
                for (i = 0; i < 40 && clk_term !== 1'b1; i++) @(negedge i_clk);
                check("clock termination", 1, clk_term);
                for (i = 0; i < 80 && hs_active !== 1'b1; i++) @(negedge i_clk);
                check("hs receive", 1, hs_active);
                check("data termination", {NL{1'b1}}, data_term);
                for (i = 0; i < 200 && hs_skip !== 1'b1; i++) @(negedge i_clk);
                check("skip at exit", 1, hs_skip);
                check("hs after exit", 0, hs_active);
                @(negedge i_clk);
                check("skip length", 0, hs_skip);
                check("termination off", 0, data_term);
            end
        join
        repeat (8) @(negedge i_clk);
        check("type reports", 1, pix_cnt);
        check("format", fmt, pix_seen.fmt);
        check("code", code, pix_seen.code);
        check("unknown flag", bad, pix_seen.bad);
        check("clock termination off", 0, clk_term);
    endtask : t_burst

    // Main sequence
    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        @(negedge i_clk);
        check("reset level", LP_11, dev_lp);
        check("reset drive", 0, dev_oe);
        check("reset terms", 0, {data_term, clk_term, hs_active, pix_vld});
        t_glitch();
        t_turn();
        t_freeze();
        for (int k = 0; k < 5; k++) begin
            t_burst(codes[k], fmts[k], k == 4);
        end
        complete_run();
    end

    // Watchdog well beyond the expected run of about 20 us
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
